// ### logic/swc_pkg.sv
// shared constants and types for the sleep and wake controller
`default_nettype none
package swc_pkg;
   // register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // interrupt sources seen by the wake detector
   localparam int SRC_N = 8;
   localparam int CLKSW_SRC = 7;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LPDLY = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
   localparam logic [7:0] ADDR_WAKE_SRC = 8'h18;
   // control fields
   localparam int CTRL_LP_BIT = 0;
   // status fields
   localparam int ST_TO_BIT = 0;
   localparam int ST_PD_BIT = 1;
   localparam int ST_ASLEEP_BIT = 2;
   localparam int ST_LP_BIT = 3;
   localparam int ST_GIE_BIT = 4;
   // event bits
   localparam int EV_N = 3;
   localparam int EV_ENTER = 0;
   localparam int EV_NOP = 1;
   localparam int EV_WAKE = 2;
   // reset values
   localparam logic RST_TO = 1'b1;
   localparam logic RST_PD = 1'b1;
   localparam logic RST_LP = 1'b0;
   // timing
   localparam int DLY_W = 16;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LP_WAKE_NS = 2000;
   localparam int LP_WAKE_CYC_INT =
      (LP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DLY_W-1:0] LP_WAKE_CYCLES = DLY_W'(LP_WAKE_CYC_INT);
   localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;
   // sleep instruction execution length
   localparam int EXEC_W = 2;
   localparam logic [EXEC_W-1:0] EXEC_LAST = 2'h1;
   localparam logic [EXEC_W-1:0] EXEC_ONE = 2'h1;

   typedef enum logic [1:0] {
      SWC_AWAKE = 2'b00,
      SWC_EXEC = 2'b01,
      SWC_SLEEP = 2'b11,
      SWC_SETTLE = 2'b10
   } swc_state_type;
endpackage : swc_pkg
`default_nettype wire

// ### logic/swc_wake_detect.sv
// wake condition from enabled and pending interrupt sources
`default_nettype none
module swc_wake_detect (
   input wire logic [swc_pkg::SRC_N-1:0] i_src_enable,
   input wire logic [swc_pkg::SRC_N-1:0] i_src_pending,
   output logic [swc_pkg::SRC_N-1:0] o_hits,
   output logic o_wake
);
   genvar g;
   generate
      for (g = 0; g < swc_pkg::SRC_N; g = g + 1) begin : g_src
         if (g == swc_pkg::CLKSW_SRC) begin : g_clksw
            assign o_hits[g] = 1'b0; // R1
         end else begin : g_norm
            assign o_hits[g] = i_src_enable[g] & i_src_pending[g]; // R1
         end
      end
   endgenerate
   assign o_wake = |o_hits;
endmodule : swc_wake_detect
`default_nettype wire

// ### logic/swc_delay_counter.sv
// loadable down counter for the low-power wake delay
`default_nettype none
module swc_delay_counter (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [swc_pkg::DLY_W-1:0] i_count,
   output logic o_done
);
   logic [swc_pkg::DLY_W-1:0] cnt;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cnt <= '0;
      end else if (i_load) begin
         cnt <= (i_count == '0) ? swc_pkg::DLY_ONE : i_count;
      end else if (cnt != '0) begin
         cnt <= cnt - swc_pkg::DLY_ONE;
      end
   end

   assign o_done = (cnt == swc_pkg::DLY_ONE);
endmodule : swc_delay_counter
`default_nettype wire

// ### logic/swc_sleep_wake_controller.sv
// sleep entry and wake-up control for the processor core
//
// What this block does
// R1: enabled pending source wakes; clock switch excluded
// R2: wake already pending makes sleep a no-op
// R3: no-op sleep leaves watchdog untouched
// R4: no-op sleep leaves timeout, powerdown flags unchanged
// R5: late wake completes sleep, then wakes immediately
// R6: completed sleep clears watchdog
// R7: completed sleep sets timeout, clears powerdown
// R8: powerdown stays set after no-op sleep
// R9: low-power select puts regulator low in sleep
// R10: select clear keeps regulator normal, fast exit
// R11: low-power wake inserts regulator settle delay
// R12: settle delay is a programmable cycle count
`default_nettype none
module swc_sleep_wake_controller (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_sleep_exec,
   input wire logic i_clrwdt_exec,
   input wire logic i_global_irq_enable,
   input wire logic [swc_pkg::SRC_N-1:0] i_src_enable,
   input wire logic [swc_pkg::SRC_N-1:0] i_src_pending,
   input wire logic [swc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [swc_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [swc_pkg::DATA_W-1:0] o_rdata,
   output logic o_irq,
   output logic o_core_asleep,
   output logic o_sleep_nop,
   output logic o_wake,
   output logic o_watchdog_clear,
   output logic o_timeout_flag,
   output logic o_powerdown_flag,
   output logic o_regulator_low_power
);
   swc_pkg::swc_state_type state;
   swc_pkg::swc_state_type next_state;
   logic [swc_pkg::EXEC_W-1:0] exec_cnt;
   logic wake_seen;
   logic wake_now;
   logic [swc_pkg::SRC_N-1:0] src_hits;
   logic regulator_low_power_select;
   logic lp_active;
   logic [swc_pkg::DLY_W-1:0] lp_delay;
   logic dly_done;
   logic dly_load;
   logic sleep_accept;
   logic sleep_nop;
   logic sleep_complete;
   logic wake_event;
   logic [swc_pkg::EV_N-1:0] ev_set;
   logic [swc_pkg::EV_N-1:0] irq_stat;
   logic [swc_pkg::EV_N-1:0] irq_en;
   logic [swc_pkg::EV_N-1:0] irq_clr;
   logic [swc_pkg::EV_N-1:0] next_irq_stat;
   logic [swc_pkg::SRC_N-1:0] wake_src;
   logic [swc_pkg::DATA_W-1:0] next_rdata;

   // wake detection and settle timing
   swc_wake_detect u_detect (
      .i_src_enable(i_src_enable),
      .i_src_pending(i_src_pending),
      .o_hits(src_hits),
      .o_wake(wake_now)
   );

   swc_delay_counter u_settle (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_load(dly_load),
      .i_count(lp_delay),
      .o_done(dly_done)
   );

   // sleep request decode
   assign sleep_accept = (state == swc_pkg::SWC_AWAKE) && i_sleep_exec
      && !wake_now; // R2
   assign sleep_nop = (state == swc_pkg::SWC_AWAKE) && i_sleep_exec
      && wake_now; // R2
   assign sleep_complete = (state == swc_pkg::SWC_EXEC)
      && (exec_cnt == swc_pkg::EXEC_LAST); // R5
   assign wake_event = (state != swc_pkg::SWC_AWAKE)
      && (next_state == swc_pkg::SWC_AWAKE);
   assign dly_load = (state == swc_pkg::SWC_SLEEP)
      && (next_state == swc_pkg::SWC_SETTLE); // R11

   // sequencing
   always_comb begin
      next_state = state;
      case (state)
         swc_pkg::SWC_AWAKE: begin
            if (sleep_accept) begin
               next_state = swc_pkg::SWC_EXEC;
            end
         end
         swc_pkg::SWC_EXEC: begin
            if (sleep_complete) begin
               if (wake_seen || wake_now) begin
                  next_state = swc_pkg::SWC_AWAKE; // R5
               end else begin
                  next_state = swc_pkg::SWC_SLEEP;
               end
            end
         end
         swc_pkg::SWC_SLEEP: begin
            if (wake_now) begin
               if (lp_active) begin
                  next_state = swc_pkg::SWC_SETTLE; // R11
               end else begin
                  next_state = swc_pkg::SWC_AWAKE; // R10
               end
            end
         end
         swc_pkg::SWC_SETTLE: begin
            if (dly_done) begin
               next_state = swc_pkg::SWC_AWAKE; // R11
            end
         end
         default: begin
            next_state = swc_pkg::SWC_AWAKE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state <= swc_pkg::SWC_AWAKE;
      end else begin
         state <= next_state;
      end
   end

   // sleep instruction execution length
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         exec_cnt <= '0;
      end else if (state == swc_pkg::SWC_EXEC) begin
         exec_cnt <= exec_cnt + swc_pkg::EXEC_ONE;
      end else begin
         exec_cnt <= '0;
      end
   end

   // wake arriving while the instruction executes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wake_seen <= 1'b0;
      end else if (state == swc_pkg::SWC_EXEC) begin
         wake_seen <= wake_seen | wake_now; // R5
      end else begin
         wake_seen <= 1'b0;
      end
   end

   // regulator mode latched on sleep entry
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         lp_active <= swc_pkg::RST_LP;
      end else if (sleep_accept) begin
         lp_active <= regulator_low_power_select; // R9
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_regulator_low_power <= 1'b0;
      end else begin
         o_regulator_low_power <= (next_state == swc_pkg::SWC_SLEEP)
            && lp_active; // R9 R10
      end
   end

   // core handshake outputs
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_core_asleep <= 1'b0;
         o_sleep_nop <= 1'b0;
         o_wake <= 1'b0;
         o_watchdog_clear <= 1'b0;
      end else begin
         o_core_asleep <= (next_state != swc_pkg::SWC_AWAKE);
         o_sleep_nop <= sleep_nop; // R2
         o_wake <= wake_event; // R5
         o_watchdog_clear <= sleep_complete; // R3 R6
      end
   end

   // timeout and powerdown flags
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_timeout_flag <= swc_pkg::RST_TO;
         o_powerdown_flag <= swc_pkg::RST_PD;
      end else if (sleep_complete) begin // R4
         o_timeout_flag <= 1'b1; // R7
         o_powerdown_flag <= 1'b0; // R7
      end else if (i_clrwdt_exec) begin
         o_timeout_flag <= 1'b1;
         o_powerdown_flag <= 1'b1;
      end
   end

   // sources that caused the last wake
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wake_src <= '0;
      end else if (wake_event || sleep_nop) begin
         wake_src <= src_hits;
      end
   end

   // software registers
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         regulator_low_power_select <= swc_pkg::RST_LP;
         lp_delay <= swc_pkg::LP_WAKE_CYCLES;
         irq_en <= '0;
      end else if (i_wr) begin
         case (i_addr)
            swc_pkg::ADDR_CTRL: begin
               regulator_low_power_select <=
                  i_wdata[swc_pkg::CTRL_LP_BIT]; // R9
            end
            swc_pkg::ADDR_LPDLY: begin
               lp_delay <= i_wdata[swc_pkg::DLY_W-1:0]; // R12
            end
            swc_pkg::ADDR_IRQ_EN: begin
               irq_en <= i_wdata[swc_pkg::EV_N-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // event status, set wins over clear
   always_comb begin
      ev_set = '0;
      ev_set[swc_pkg::EV_ENTER] = sleep_accept;
      ev_set[swc_pkg::EV_NOP] = sleep_nop;
      ev_set[swc_pkg::EV_WAKE] = wake_event;
      irq_clr = '0;
      if (i_wr && (i_addr == swc_pkg::ADDR_IRQ_CLR)) begin
         irq_clr = i_wdata[swc_pkg::EV_N-1:0];
      end
      next_irq_stat = ev_set | (irq_stat & ~irq_clr);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         irq_stat <= '0;
         o_irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         o_irq <= |(next_irq_stat & irq_en);
      end
   end

   // read data, zero for unmapped and write-only
   always_comb begin
      next_rdata = '0;
      case (i_addr)
         swc_pkg::ADDR_CTRL: begin
            next_rdata[swc_pkg::CTRL_LP_BIT] = regulator_low_power_select;
         end
         swc_pkg::ADDR_LPDLY: begin
            next_rdata[swc_pkg::DLY_W-1:0] = lp_delay;
         end
         swc_pkg::ADDR_STATUS: begin
            next_rdata[swc_pkg::ST_TO_BIT] = o_timeout_flag;
            next_rdata[swc_pkg::ST_PD_BIT] = o_powerdown_flag; // R8
            next_rdata[swc_pkg::ST_ASLEEP_BIT] = o_core_asleep;
            next_rdata[swc_pkg::ST_LP_BIT] = o_regulator_low_power;
            next_rdata[swc_pkg::ST_GIE_BIT] = i_global_irq_enable;
         end
         swc_pkg::ADDR_IRQ_STAT: begin
            next_rdata[swc_pkg::EV_N-1:0] = irq_stat;
         end
         swc_pkg::ADDR_IRQ_EN: begin
            next_rdata[swc_pkg::EV_N-1:0] = irq_en;
         end
         swc_pkg::ADDR_WAKE_SRC: begin
            next_rdata[swc_pkg::SRC_N-1:0] = wake_src;
         end
         default: begin
            next_rdata = '0;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= '0;
      end
   end

   // helper logic for the checks below
   logic [swc_pkg::DLY_W-1:0] settle_cycles;
   logic [swc_pkg::DLY_W-1:0] settle_req;
   logic [swc_pkg::SRC_N-1:0] clksw_mask;

   always_comb begin
      clksw_mask = '0;
      clksw_mask[swc_pkg::CLKSW_SRC] = 1'b1;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         settle_cycles <= '0;
         settle_req <= swc_pkg::DLY_ONE;
      end else begin
         if (dly_load) begin
            settle_req <= (lp_delay == '0) ? swc_pkg::DLY_ONE : lp_delay;
         end
         if (state == swc_pkg::SWC_SETTLE) begin
            settle_cycles <= settle_cycles + swc_pkg::DLY_ONE;
         end else begin
            settle_cycles <= '0;
         end
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_nop;
      state == swc_pkg::SWC_AWAKE && i_sleep_exec && wake_now
         && !i_clrwdt_exec;
   endsequence

   sequence s_enter_then_wake;
      sleep_accept ##1 wake_now;
   endsequence

   property p_clksw_ignored;
      state == swc_pkg::SWC_SLEEP
         && ((i_src_enable & i_src_pending & ~clksw_mask) == '0)
         |=> state == swc_pkg::SWC_SLEEP;
   endproperty
   a_clksw_ignored: assert property (p_clksw_ignored) // R1
      else $error("clock switch source woke the core");

   property p_nop_awake;
      s_nop |=> o_sleep_nop && !o_core_asleep;
   endproperty
   a_nop_awake: assert property (p_nop_awake) // R2
      else $error("pending wake did not cancel sleep");

   property p_nop_no_wdt;
      s_nop |=> !o_watchdog_clear ##1 !o_watchdog_clear;
   endproperty
   a_nop_no_wdt: assert property (p_nop_no_wdt) // R3
      else $error("watchdog cleared by cancelled sleep");

   property p_nop_flags;
      s_nop |=> $stable(o_timeout_flag) && $stable(o_powerdown_flag);
   endproperty
   a_nop_flags: assert property (p_nop_flags) // R4
      else $error("status flags changed by cancelled sleep");

   property p_late_wake;
      s_enter_then_wake |-> ##1 !o_wake ##1 o_watchdog_clear && o_wake;
   endproperty
   a_late_wake: assert property (p_late_wake) // R5
      else $error("late wake did not finish sleep then wake");

   property p_wdt_clear;
      sleep_complete |=> o_watchdog_clear;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) // R6
      else $error("completed sleep did not clear watchdog");

   property p_flags_sleep;
      sleep_complete |=> o_timeout_flag && !o_powerdown_flag;
   endproperty
   a_flags_sleep: assert property (p_flags_sleep) // R7
      else $error("completed sleep flags wrong");

   property p_pd_after_nop;
      s_nop ##0 o_powerdown_flag |=> o_powerdown_flag[*2];
   endproperty
   a_pd_after_nop: assert property (p_pd_after_nop) // R8
      else $error("powerdown flag lost after cancelled sleep");

   property p_lp_in_sleep;
      state == swc_pkg::SWC_SLEEP && lp_active
         |-> o_regulator_low_power && o_core_asleep;
   endproperty
   a_lp_in_sleep: assert property (p_lp_in_sleep) // R9
      else $error("regulator not low power in sleep");

   property p_normal_fast;
      state == swc_pkg::SWC_SLEEP && wake_now && !lp_active
         |-> !o_regulator_low_power ##1 o_wake && !o_core_asleep;
   endproperty
   a_normal_fast: assert property (p_normal_fast) // R10
      else $error("normal mode wake not immediate");

   property p_lp_settle;
      state == swc_pkg::SWC_SLEEP && wake_now && lp_active
         |=> state == swc_pkg::SWC_SETTLE && !o_wake
         && !o_regulator_low_power && o_core_asleep;
   endproperty
   a_lp_settle: assert property (p_lp_settle) // R11
      else $error("low power wake skipped settle delay");

   property p_settle_len;
      state == swc_pkg::SWC_SETTLE && next_state == swc_pkg::SWC_AWAKE
         |-> settle_cycles + swc_pkg::DLY_ONE == settle_req;
   endproperty
   a_settle_len: assert property (p_settle_len) // R12
      else $error("settle delay length wrong");
endmodule : swc_sleep_wake_controller
`default_nettype wire

// ### test/swc_seq_model.sv
// sequencer and interrupt source model facing the controller
`default_nettype none
module swc_seq_model (
   input wire logic i_core_clk,
   output logic o_sleep_exec,
   output logic o_clrwdt_exec,
   output logic o_global_irq_enable,
   output logic [swc_pkg::SRC_N-1:0] o_src_enable,
   output logic [swc_pkg::SRC_N-1:0] o_src_pending
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_sleep_exec = 1'b0;
      o_clrwdt_exec = 1'b0;
      o_global_irq_enable = 1'b0;
      o_src_enable = 8'h00;
      o_src_pending = 8'h00;
   end

   // one-cycle sleep instruction, ends at the sampling edge
   task automatic issue_sleep();
      @(posedge i_core_clk);
      o_sleep_exec <= 1'b1;
      @(posedge i_core_clk);
      o_sleep_exec <= 1'b0;
   endtask : issue_sleep

   // one-cycle clear-watchdog instruction
   task automatic issue_clrwdt();
      @(posedge i_core_clk);
      o_clrwdt_exec <= 1'b1;
      @(posedge i_core_clk);
      o_clrwdt_exec <= 1'b0;
   endtask : issue_clrwdt

   // source levels, called at a rising edge
   task automatic set_src(input logic [7:0] en, input logic [7:0] pend);
      o_src_enable <= en;
      o_src_pending <= pend;
   endtask : set_src

   // global interrupt enable level, called at a rising edge
   task automatic set_gie(input logic v);
      o_global_irq_enable <= v;
   endtask : set_gie
endmodule : swc_seq_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the sleep and wake controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk;
   logic rst;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr_s;
   logic rd_s;
   logic [31:0] rdata;
   logic irq;
   logic asleep;
   logic sleep_nop;
   logic wake;
   logic wdt_clr;
   logic to_flag;
   logic pd_flag;
   logic reg_lp;
   logic sleep_exec;
   logic clrwdt_exec;
   logic global_irq_enable;
   logic [7:0] src_en;
   logic [7:0] src_pend;
   int num_errors;
   int num_checks;
   int n;

   swc_sleep_wake_controller i_dut (
      .i_core_clk(core_clk),
      .i_rst(rst),
      .i_sleep_exec(sleep_exec),
      .i_clrwdt_exec(clrwdt_exec),
      .i_global_irq_enable(global_irq_enable),
      .i_src_enable(src_en),
      .i_src_pending(src_pend),
      .i_addr(addr),
      .i_wdata(wdata),
      .i_wr(wr_s),
      .i_rd(rd_s),
      .o_rdata(rdata),
      .o_irq(irq),
      .o_core_asleep(asleep),
      .o_sleep_nop(sleep_nop),
      .o_wake(wake),
      .o_watchdog_clear(wdt_clr),
      .o_timeout_flag(to_flag),
      .o_powerdown_flag(pd_flag),
      .o_regulator_low_power(reg_lp)
   );

   swc_seq_model i_seq (
      .i_core_clk(core_clk),
      .o_sleep_exec(sleep_exec),
      .o_clrwdt_exec(clrwdt_exec),
      .o_global_irq_enable(global_irq_enable),
      .o_src_enable(src_en),
      .o_src_pending(src_pend)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge core_clk);
      wr_s <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge core_clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask : bus_rd

   // advance one cycle and let registered outputs settle
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask : step

   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   initial begin
      num_errors = 0;
      num_checks = 0;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      // defaults and register map
      bus_rd(swc_pkg::ADDR_LPDLY, 32'h000000C8);
      bus_rd(swc_pkg::ADDR_STATUS, 32'h00000003);
      bus_rd(8'h1C, 32'h0);
      bus_rd(swc_pkg::ADDR_IRQ_CLR, 32'h0);
      bus_wr(swc_pkg::ADDR_LPDLY, 32'h3);
      bus_wr(swc_pkg::ADDR_IRQ_EN, 32'h7);
      // wake already pending: sleep becomes a no-op
      @(posedge core_clk);
      i_seq.set_src(8'h01, 8'h01);
      i_seq.issue_sleep();
      #1 chk(sleep_nop, 1'b1);
      for (int i = 0; i < 4; i++) begin
         chk(asleep, 1'b0);
         chk(wdt_clr, 1'b0);
         chk(to_flag, 1'b1);
         chk(pd_flag, 1'b1);
         step();
      end
      bus_rd(swc_pkg::ADDR_IRQ_STAT, 32'h2);
      chk(irq, 1'b1);
      bus_wr(swc_pkg::ADDR_IRQ_CLR, 32'h7);
      bus_rd(swc_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(irq, 1'b0);
      // clock switch source never wakes; completed sleep
      @(posedge core_clk);
      i_seq.set_src(8'h81, 8'h80);
      i_seq.issue_sleep();
      #1 chk(sleep_nop, 1'b0);
      chk(asleep, 1'b1);
      step();
      chk(wdt_clr, 1'b0);
      step();
      chk(wdt_clr, 1'b1);
      chk(to_flag, 1'b1);
      chk(pd_flag, 1'b0);
      chk(reg_lp, 1'b0);
      repeat (5) step();
      chk(asleep, 1'b1);
      @(posedge core_clk);
      i_seq.set_src(8'h81, 8'h81);
      step();
      chk(wake, 1'b1);
      chk(asleep, 1'b0);
      bus_rd(swc_pkg::ADDR_STATUS, 32'h00000001);
      bus_rd(swc_pkg::ADDR_IRQ_STAT, 32'h5);
      bus_rd(swc_pkg::ADDR_WAKE_SRC, 32'h1);
      bus_wr(swc_pkg::ADDR_IRQ_CLR, 32'h7);
      // wake arriving during execution
      i_seq.issue_clrwdt();
      #1 step();
      chk(pd_flag, 1'b1);
      @(posedge core_clk);
      i_seq.set_src(8'h01, 8'h00);
      i_seq.issue_sleep();
      i_seq.set_src(8'h01, 8'h01);
      #1 chk(asleep, 1'b1);
      chk(sleep_nop, 1'b0);
      step();
      step();
      chk(wake, 1'b1);
      chk(asleep, 1'b0);
      chk(wdt_clr, 1'b1);
      chk(pd_flag, 1'b0);
      @(posedge core_clk);
      i_seq.set_gie(1'b1);
      bus_rd(swc_pkg::ADDR_STATUS, 32'h00000011);
      @(posedge core_clk);
      i_seq.set_gie(1'b0);
      // low-power sleep with masked interrupt
      bus_wr(swc_pkg::ADDR_IRQ_CLR, 32'h7);
      bus_wr(swc_pkg::ADDR_IRQ_EN, 32'h0);
      bus_wr(swc_pkg::ADDR_CTRL, 32'h1);
      bus_rd(swc_pkg::ADDR_CTRL, 32'h1);
      @(posedge core_clk);
      i_seq.set_src(8'h01, 8'h00);
      i_seq.issue_sleep();
      #1 step();
      step();
      chk(reg_lp, 1'b1);
      bus_rd(swc_pkg::ADDR_STATUS, 32'h0000000D);
      @(posedge core_clk);
      i_seq.set_src(8'h01, 8'h01);
      step();
      chk(reg_lp, 1'b0);
      chk(wake, 1'b0);
      chk(asleep, 1'b1);
      n = 1;
      while (wake !== 1'b1 && n < 20) begin
         step();
         n++;
      end
      chk(n, 32'd4);
      chk(asleep, 1'b0);
      bus_rd(swc_pkg::ADDR_IRQ_STAT, 32'h5);
      chk(irq, 1'b0);
      bus_wr(swc_pkg::ADDR_IRQ_EN, 32'h4);
      step();
      chk(irq, 1'b1);
      bus_wr(swc_pkg::ADDR_IRQ_CLR, 32'h7);
      step();
      chk(irq, 1'b0);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
